// [common/rdcfg_pkg.sv]
// Behaviour
// - Pin mode EQ index is 4*high+low.
// - Control strap L0 selects strap settings.
// - Control strap L3 enables serial configuration.
// - Slave mode register write sets equalization.
// - Gain and swing straps decode to DC gain.
// - Both straps floating give 0 dB.
// - Detect cycle starts at reset, powerdown, retrigger write.
// - Detect policy L0 needs two detections.
// - Detect policy L1 needs three detections.
// - Detect policy L2 needs one detection.
// - Hi-Z before detect, 50 ohm after.
// - Policy L3 disables detect, 50 ohm except in powerdown.
// - Powerdown high resets detect, Hi-Z, standby.
// - Active mode when powered and policy L0-L2.
// - First powerdown controls ch1-2, second ch3-4.
// - Four-level straps resolve to levels zero..three.
// - Serial interface runs up to 400 kHz.
// - Slave address is 0x18 plus strap index.
`default_nettype none
package rdcfg_pkg;
   localparam logic [1:0] LVL_0 = 2'h0;
   localparam logic [1:0] LVL_1 = 2'h1;
   localparam logic [1:0] LVL_2 = 2'h2;
   localparam logic [1:0] LVL_3 = 2'h3;
   localparam logic [6:0] SLAVE_ADDR_BASE = 7'h18;
   // Enforced by the bus master, nothing here can slow it
   localparam int SERIAL_MAX_KHZ = 400;
   // Valid detections needed per policy level
   localparam logic [1:0] NEED_L0 = 2'h2;
   localparam logic [1:0] NEED_L1 = 2'h3;
   localparam logic [1:0] NEED_L2 = 2'h1;
   // DC gain codes
   localparam logic [2:0] GAIN_P3P5 = 3'h0;
   localparam logic [2:0] GAIN_0 = 3'h1;
   localparam logic [2:0] GAIN_M1P5 = 3'h2;
   localparam logic [2:0] GAIN_M3P5 = 3'h3;
   localparam logic [2:0] GAIN_M6 = 3'h4;
   // APB register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_STRAPS = 8'h08;
   localparam int CTRL_EQ_LSB = 0;
   localparam int CTRL_GAIN_LSB = 4;
   localparam int CTRL_REDET_BIT = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
   typedef enum logic [1:0] {
      RDCFG_IDLE = 2'b00,
      RDCFG_SEEK = 2'b01,
      RDCFG_FOUND = 2'b10,
      RDCFG_BUFFER = 2'b11
   } rdcfg_state_t;
   typedef struct packed {
      logic [1:0] eq_low;
      logic [1:0] eq_high;
      logic [1:0] mode;
      logic [1:0] gain;
      logic [1:0] swing;
      logic [1:0] policy;
   } rdcfg_straps_t;
   typedef struct packed {
      logic [3:0] eq_index;
      logic [2:0] dc_gain;
      logic [6:0] slave_addr;
      logic serial_mode;
   } rdcfg_cfg_t;
endpackage
`default_nettype wire

// [rtl/rdcfg_top.sv]
`default_nettype none
module rdcfg_top #(
   parameter int PAIRS = 2
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic ARST_N,
   // Four-level straps, already resolved to level codes
   input wire rdcfg_pkg::rdcfg_straps_t STRAPS,
   // Power-down per channel pair
   input wire logic [PAIRS-1:0] POWERDOWN,
   // Far-end termination seen, per pair, one pulse per valid detection
   input wire logic [PAIRS-1:0] DETECT_VALID,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Datapath settings
   output rdcfg_pkg::rdcfg_cfg_t CFG,
   output logic [PAIRS-1:0] TERM_50,
   output logic [PAIRS-1:0] STANDBY,
   output logic [PAIRS-1:0] DETECT_ACTIVE
);
   // Strap latch one cycle after release
   logic latched;
   logic next_latched;
   rdcfg_pkg::rdcfg_straps_t straps;
   rdcfg_pkg::rdcfg_straps_t next_straps;
   logic [31:0] ctrl;
   logic [31:0] next_ctrl;
   logic [31:0] next_prdata;
   logic next_pslverr;
   rdcfg_pkg::rdcfg_cfg_t next_cfg;

   function automatic logic [2:0] gain_decode(input logic [1:0] g, input logic [1:0] s);
      logic [2:0] r;
      r = rdcfg_pkg::GAIN_0; // Undefined combos fall back to 0 dB
      if (g == rdcfg_pkg::LVL_3 && s == rdcfg_pkg::LVL_2) r = rdcfg_pkg::GAIN_P3P5;
      else if (g == rdcfg_pkg::LVL_2 && s == rdcfg_pkg::LVL_3) r = rdcfg_pkg::GAIN_M1P5;
      else if (g == rdcfg_pkg::LVL_2 && s == rdcfg_pkg::LVL_1) r = rdcfg_pkg::GAIN_M3P5;
      else if (g == rdcfg_pkg::LVL_2 && s == rdcfg_pkg::LVL_0) r = rdcfg_pkg::GAIN_M6;
      return r;
   endfunction

   wire logic acc = PSEL && PENABLE;
   // Answer staged in setup so it stands at the access edge
   wire logic setup = PSEL && !PENABLE;
   wire logic wr_ctrl = acc && PWRITE && PADDR == rdcfg_pkg::REG_CTRL;
   wire logic serial = straps.mode == rdcfg_pkg::LVL_3;
   wire logic [3:0] pin_eq = {straps.eq_high, straps.eq_low}; // 4*high+low
   wire logic redetect = wr_ctrl && serial && PWDATA[rdcfg_pkg::CTRL_REDET_BIT];

   always_comb begin
      next_latched = 1'b1;
      next_straps = latched ? straps : STRAPS; // Held until reset
      next_ctrl = ctrl;
      if (wr_ctrl && serial) begin
         // Retrigger bit is never stored, so it reads back zero
         next_ctrl = 32'h0;
         next_ctrl[rdcfg_pkg::CTRL_EQ_LSB +: 4] = PWDATA[rdcfg_pkg::CTRL_EQ_LSB +: 4];
         next_ctrl[rdcfg_pkg::CTRL_GAIN_LSB +: 3] = PWDATA[rdcfg_pkg::CTRL_GAIN_LSB +: 3];
      end
      next_cfg.slave_addr = rdcfg_pkg::SLAVE_ADDR_BASE + {3'h0, pin_eq};
      next_cfg.serial_mode = serial;
      if (serial) begin
         next_cfg.eq_index = ctrl[rdcfg_pkg::CTRL_EQ_LSB +: 4];
         next_cfg.dc_gain = ctrl[rdcfg_pkg::CTRL_GAIN_LSB +: 3];
      end else begin
         // Other mode levels also use straps; serial needs L3
         next_cfg.eq_index = pin_eq;
         next_cfg.dc_gain = gain_decode(straps.gain, straps.swing);
      end
      next_pslverr = 1'b0;
      next_prdata = PRDATA;
      if (setup && !PWRITE) begin
         if (PADDR == rdcfg_pkg::REG_CTRL) next_prdata = ctrl;
         else if (PADDR == rdcfg_pkg::REG_STATUS) next_prdata = 32'({STANDBY, TERM_50});
         else if (PADDR == rdcfg_pkg::REG_STRAPS) next_prdata = {20'h0, straps};
         else begin
            next_prdata = 32'h0;
            next_pslverr = 1'b1;
         end
      end else if (setup && PWRITE) begin
         if (PADDR != rdcfg_pkg::REG_CTRL) next_pslverr = 1'b1;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         latched <= 1'b0;
         straps <= '0;
         ctrl <= rdcfg_pkg::CTRL_RESET;
         PRDATA <= 32'h0;
         PSLVERR <= 1'b0;
         CFG <= '0;
      end else begin
         latched <= next_latched;
         straps <= next_straps;
         ctrl <= next_ctrl;
         PRDATA <= next_prdata;
         PSLVERR <= next_pslverr;
         CFG <= next_cfg;
      end
   end
   assign PREADY = 1'b1;

   // One detect machine per pair; pair 0 is ch1-2, pair 1 is ch3-4
   genvar p;
   generate
      for (p = 0; p < PAIRS; p++) begin : g_pair
         rdcfg_pkg::rdcfg_state_t state;
         rdcfg_pkg::rdcfg_state_t next_state;
         logic [1:0] hits;
         logic [1:0] next_hits;
         logic [1:0] need;
         always_comb begin
            case (straps.policy)
               rdcfg_pkg::LVL_0: need = rdcfg_pkg::NEED_L0;
               rdcfg_pkg::LVL_1: need = rdcfg_pkg::NEED_L1;
               default: need = rdcfg_pkg::NEED_L2;
            endcase
            next_state = state;
            next_hits = hits;
            case (state)
               rdcfg_pkg::RDCFG_IDLE: begin
                  // Leaving idle starts a fresh cycle
                  next_hits = 2'h0;
                  if (latched) begin
                     if (straps.policy == rdcfg_pkg::LVL_3) next_state = rdcfg_pkg::RDCFG_BUFFER;
                     else next_state = rdcfg_pkg::RDCFG_SEEK;
                  end
               end
               rdcfg_pkg::RDCFG_SEEK: begin
                  if (DETECT_VALID[p]) begin
                     next_hits = hits + 2'h1;
                     if (hits + 2'h1 >= need) next_state = rdcfg_pkg::RDCFG_FOUND;
                  end
               end
               default: ;
            endcase
            // Powerdown dominates strap policy
            if (POWERDOWN[p] || redetect) begin
               next_state = rdcfg_pkg::RDCFG_IDLE;
               next_hits = 2'h0;
            end
         end
         always_ff @(posedge MCLK or negedge ARST_N) begin
            if (!ARST_N) begin
               state <= rdcfg_pkg::RDCFG_IDLE;
               hits <= 2'h0;
            end else begin
               state <= next_state;
               hits <= next_hits;
            end
         end
         // 50 ohm only after detect or in buffer mode
         assign TERM_50[p] = state == rdcfg_pkg::RDCFG_FOUND || state == rdcfg_pkg::RDCFG_BUFFER;
         assign STANDBY[p] = POWERDOWN[p];
         assign DETECT_ACTIVE[p] = state == rdcfg_pkg::RDCFG_SEEK;
      end
   endgenerate
endmodule // rdcfg_top
`default_nettype wire

// [tb/rdcfg_far_end.sv]
`default_nettype none
module rdcfg_far_end (
   // Probe side
   input wire logic clk,
   input wire logic [1:0] hit,
   input wire logic [1:0] probing,
   output logic [1:0] DETECT_VALID
);
   timeunit 1ns;
   timeprecision 1ns;
   // Answers only while probed, so stray hits never count
   always_ff @(posedge clk) DETECT_VALID <= hit & probing;
endmodule // rdcfg_far_end
`default_nettype wire

// [tb/rdcfg_monitor.sv]
`default_nettype none
module rdcfg_monitor (
   // Watched ports
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire rdcfg_pkg::rdcfg_straps_t STRAPS,
   input wire logic [1:0] POWERDOWN,
   input wire rdcfg_pkg::rdcfg_cfg_t CFG,
   input wire logic [1:0] TERM_50,
   input wire logic [1:0] STANDBY,
   input wire logic [1:0] DETECT_ACTIVE
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] age;
   rdcfg_pkg::rdcfg_straps_t h;
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) age <= 2'h0;
      else if (age != 2'h3) age <= age + 2'h1;
   end
   // Own copy, the pins may wander after the latch
   always_ff @(posedge MCLK) if (age == 2'h0) h <= STRAPS;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!ARST_N);
   a_standby_pin: assert property (STANDBY == POWERDOWN) else $error("standby");
   a_pd_hiz: assert property ($past(POWERDOWN[0]) |-> !TERM_50[0]) else $error("pd");
   a_pd_pair: assert property ($past(POWERDOWN[1]) |-> !DETECT_ACTIVE[1])
      else $error("pd pair");
   a_seek_hiz: assert property ((DETECT_ACTIVE & TERM_50) == 2'h0) else $error("seek");
   a_eq_pin: assert property (age[1] && h.mode != 2'h3 |-> CFG.eq_index == {h.eq_high, h.eq_low})
      else $error("eq");
   a_serial_sel: assert property (age[1] |-> CFG.serial_mode == (h.mode == 2'h3))
      else $error("mode");
   a_addr_map: assert property (age[1] |-> CFG.slave_addr == 7'h18 + {h.eq_high, h.eq_low})
      else $error("addr");
   a_buffer_term: assert property (age[1] && h.policy == 2'h3 && h.mode != 2'h3
      && !$past(POWERDOWN[0]) && !POWERDOWN[0] |-> TERM_50[0]) else $error("buffer");
   c_found: cover property ($rose(TERM_50[0]));
   c_seek: cover property (DETECT_ACTIVE[1]);
   c_standby: cover property (STANDBY == 2'h1);
   c_tied: cover property (STANDBY == 2'h3);
endmodule // rdcfg_monitor
bind rdcfg_top rdcfg_monitor u_mon (.MCLK, .ARST_N, .STRAPS, .POWERDOWN, .CFG, .TERM_50,
   .STANDBY, .DETECT_ACTIVE);
`default_nettype wire

// [tb/rdcfg_top_tb.sv]
`default_nettype none
module rdcfg_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
`define CK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
   logic MCLK = 1'h0, ARST_N = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
   logic PREADY, PSLVERR;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA;
   logic [1:0] POWERDOWN = 2'h0, hit = 2'h0, DETECT_VALID, TERM_50, STANDBY, DETECT_ACTIVE;
   logic [3:0] x;
   logic [31:0] rd, ctrl0 = rdcfg_pkg::CTRL_RESET;
   logic err;
   rdcfg_pkg::rdcfg_straps_t STRAPS = '0;
   rdcfg_pkg::rdcfg_cfg_t CFG;
   int fail_count = 0, comparisons = 0;
   // Gain, swing, policy per test; gain codes run 0..4, the last test is serial
   logic [5:0] tab [6] = '{6'h38, 6'h29, 6'h2e, 6'h27, 6'h20, 6'h38};
   int need [6] = '{2, 3, 1, 0, 2, 2};
   rdcfg_top DUT (.MCLK, .ARST_N, .STRAPS, .POWERDOWN, .DETECT_VALID, .PSEL, .PENABLE, .PWRITE,
      .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CFG, .TERM_50, .STANDBY, .DETECT_ACTIVE);
   rdcfg_far_end FAR (.clk(MCLK), .hit, .probing(DETECT_ACTIVE), .DETECT_VALID);
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      PSEL <= 1'h1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'h1;
      do @(posedge MCLK); while (PREADY !== 1'h1);
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
      @(posedge MCLK);
   endtask
   task automatic probe(input int n);
      repeat (n) begin
         hit <= 2'h3;
         @(posedge MCLK);
         hit <= 2'h0;
         @(posedge MCLK);
      end
      repeat (3) @(posedge MCLK);
   endtask
   task automatic close_out();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial forever #25 MCLK = ~MCLK;
   initial begin
      repeat (2000) @(posedge MCLK);
      fail_count++;
      close_out();
   end
   initial begin
      for (int i = 0; i < 6; i++) begin
         x = {2'h3 - 2'(i), 2'(i)};
         STRAPS <= {x[1:0], x[3:2], (i == 5) ? 2'h3 : 2'h0, tab[i]};
         POWERDOWN <= 2'h0;
         ARST_N <= 1'h0;
         repeat (16) @(posedge MCLK);
         ARST_N <= 1'h1;
         probe(0);
         STRAPS <= ~STRAPS;
         `CK("eq", (i == 5) ? ctrl0[3:0] : x, CFG.eq_index)
         `CK("gain", (i == 5) ? ctrl0[6:4] : 3'(i), CFG.dc_gain)
         `CK("serial", i == 5, CFG.serial_mode)
         `CK("addr", 7'h18 + x, CFG.slave_addr)
         `CK("wr addr", 8'h30 + {x, 1'b0}, {CFG.slave_addr, 1'b0})
         probe((need[i] > 0) ? need[i] - 1 : 0);
         `CK("pre", (need[i] > 0) ? 2'h0 : 2'h3, TERM_50)
         `CK("seek", (need[i] > 0) ? 2'h3 : 2'h0, DETECT_ACTIVE)
         probe(1);
         `CK("post", 2'h3, TERM_50)
         apb(1'h0, rdcfg_pkg::REG_STRAPS, 32'h0, rd, err);
         `CK("straps", {20'h0, ~STRAPS}, rd)
         apb(1'h0, 8'h40, 32'h0, rd, err);
         `CK("unmapped", 32'h0, rd)
         `CK("slverr", 1'h1, err)
         apb(1'h1, rdcfg_pkg::REG_CTRL, 32'h125, rd, err);
         @(posedge MCLK);
         `CK("ctrl", (i == 5) ? 4'h5 : x, CFG.eq_index)
         `CK("ctrl gain", (i == 5) ? 3'h2 : 3'(i), CFG.dc_gain)
         `CK("redet", (i == 5) ? 2'h0 : 2'h3, TERM_50)
         apb(1'h0, rdcfg_pkg::REG_CTRL, 32'h0, rd, err);
         `CK("readback", (i == 5) ? 32'h25 : ctrl0, rd)
         POWERDOWN <= 2'h1;
         probe(0);
         `CK("pd", (i == 5) ? 2'h0 : 2'h2, TERM_50)
         `CK("standby", 2'h1, STANDBY)
         apb(1'h0, rdcfg_pkg::REG_STATUS, 32'h0, rd, err);
         `CK("status", {28'h0, 2'h1, (i == 5) ? 2'h0 : 2'h2}, rd)
         POWERDOWN <= 2'h3;
         probe(0);
         `CK("tied", 6'h30, {STANDBY, TERM_50, DETECT_ACTIVE})
         $display("test %0d done", i);
      end
      close_out();
   end
endmodule // rdcfg_top_tb
`default_nettype wire
